// ==== rtl/word_cpu_core.sv ====
// Instruction decode, address modification and core memory access path
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns

// Functional notes
// - Words are 24 bits; memory keeps one extra parity bit per word.
// - 14-bit program counter advances by one per instruction unless changed.
// - Index register is 24 bits; only low 14 bits modify addresses.
// - 14-bit memory address register supplies every fetch and data address.
// - Fetched word goes to the work register; modification there, parity checked as the word is read.
// - 6-bit opcode register holds code of the executing instruction.
// - 25-bit memory buffer takes read words; writes come from it.
// - Valid addresses run from zero to the top of installed memory.
// - With 16K installed, the address after the top wraps to zero.
// - Reading a missing address returns an all-zero word.
// - Writing a missing address changes nothing; next instruction follows.
// - Before each access check power; on power loss halt.
// - Generate even parity on writes, check even parity on reads.
// - With parity halt enabled, a parity error halts the processor.
// - Decode ignores the most significant instruction bit.
// - Second bit from the top is the index flag.
// - Bits 2 to 8 are the opcode; bit 2 marks programmed operators.
// - Bit 9 is the indirect flag.
// - Bits 10 to 23 are the 14-bit address field.
// - Opcode 73 skips next instruction when accumulator exceeds operand.
// - Word 0 46 10000 copies extension into accumulator, clears extension.
// - Word 0 40 20001 tests the overflow indicator and resets it.
// - Indexing adds low 14 index bits to address, carry dropped.
// - Indirect flag re-decodes the effective word, one memory read per level.
// - Codes 100-177 call a code-specific routine, return address at zero.
module word_cpu_core #(
  parameter int MEM_WORDS = 4096
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [word_cpu_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [word_cpu_pkg::ADDR_W-1:0] mem_addr,
  output logic mem_read,
  output logic mem_write,
  output logic [word_cpu_pkg::MEM_W-1:0] mem_wdata,
  input wire logic [word_cpu_pkg::MEM_W-1:0] mem_rdata,
  input wire logic mem_done,
  input wire logic power_fail,
  output logic cpu_running
);
  import word_cpu_pkg::*;

  // ==========================================================
  // Registers
  logic [WORD_W-1:0] accumulator_reg;
  logic [WORD_W-1:0] extension_reg;
  logic [WORD_W-1:0] index_reg;
  logic [ADDR_W-1:0] program_counter_reg;
  logic [ADDR_W-1:0] memory_address_reg;
  logic [WORD_W-1:0] instruction_work_reg;
  logic [OPC_W-1:0] opcode_reg;
  logic [MEM_W-1:0] memory_buffer_reg;
  logic overflow;
  logic parity_halt_en;
  logic parity_err;
  logic halt_power;
  logic halt_parity;
  logic halt_instr;
  logic mem_busy;
  cpu_state_t state;
  access_purpose_t purpose;

  localparam logic [14:0] MEM_LIMIT = 15'(MEM_WORDS);

  // ==========================================================
  // Combinational helpers
  logic [ADDR_W-1:0] eff_addr;
  logic [ADDR_W-1:0] pc_next;
  logic [ADDR_W-1:0] pc_skip;
  logic addr_avail;
  logic access_done;
  logic read_parity_bad;
  logic [MEM_W-1:0] rd_word;
  logic [WORD_W-1:0] add_sum;
  logic add_ovf;
  logic is_read;
  logic wr_en;
  logic [22:0] decode_word;

  assign eff_addr = instruction_work_reg[INDEX_BIT] ?
    instruction_work_reg[ADDR_W-1:0] + index_reg[ADDR_W-1:0] :
    instruction_work_reg[ADDR_W-1:0];
  assign pc_next = program_counter_reg + 14'h0001;
  assign pc_skip = program_counter_reg + 14'h0002;
  assign addr_avail = {1'b0, memory_address_reg} < MEM_LIMIT;
  assign is_read = (purpose != PUR_STORE) && (purpose != PUR_POP);
  // A missing address completes at once, without touching memory
  assign access_done = mem_busy ? mem_done : (!power_fail && !addr_avail);
  assign rd_word = mem_busy ? mem_rdata : MEM_WORD_RESET;
  assign read_parity_bad = mem_busy && mem_done && is_read &&
    (^mem_rdata);
  assign add_sum = accumulator_reg + rd_word[WORD_W-1:0];
  assign add_ovf = (accumulator_reg[WORD_W-1] == rd_word[WORD_W-1]) &&
    (add_sum[WORD_W-1] != accumulator_reg[WORD_W-1]);
  assign wr_en = psel && penable && pready && pwrite;
  assign decode_word = instruction_work_reg[22:0];

  // ==========================================================
  // Instruction sequencer and memory access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      purpose <= PUR_FETCH;
      accumulator_reg <= WORD_RESET;
      extension_reg <= WORD_RESET;
      index_reg <= WORD_RESET;
      program_counter_reg <= ADDR_RESET;
      memory_address_reg <= ADDR_RESET;
      instruction_work_reg <= WORD_RESET;
      opcode_reg <= OPC_RESET;
      memory_buffer_reg <= MEM_WORD_RESET;
      overflow <= 1'b0;
      parity_halt_en <= 1'b0;
      parity_err <= 1'b0;
      halt_power <= 1'b0;
      halt_parity <= 1'b0;
      halt_instr <= 1'b0;
      mem_busy <= 1'b0;
      mem_read <= 1'b0;
      mem_write <= 1'b0;
      mem_wdata <= MEM_WORD_RESET;
    end else begin
      // Software side; architectural registers only while halted
      if (wr_en && paddr == REG_CTRL) begin
        parity_halt_en <= pwdata[CTRL_PARITY_HALT];
      end
      if (wr_en && paddr == REG_STATUS && pwdata[STAT_PARITY_ERR]) begin
        parity_err <= 1'b0;
      end
      if (wr_en && state == ST_IDLE) begin
        case (paddr)
          REG_CTRL: begin
            if (pwdata[CTRL_START]) begin
              state <= ST_FETCH;
              halt_power <= 1'b0;
              halt_parity <= 1'b0;
              halt_instr <= 1'b0;
            end
          end
          REG_PC: program_counter_reg <= pwdata[ADDR_W-1:0];
          REG_ACC: accumulator_reg <= pwdata[WORD_W-1:0];
          REG_EXT: extension_reg <= pwdata[WORD_W-1:0];
          REG_INDEX: index_reg <= pwdata[WORD_W-1:0];
          default: begin
          end
        endcase
      end

      case (state)
        ST_IDLE: begin
        end
        ST_FETCH: begin
          memory_address_reg <= program_counter_reg;
          purpose <= PUR_FETCH;
          state <= ST_ACCESS;
        end
        ST_MODIFY: begin
          if (instruction_work_reg[INDIRECT_BIT]) begin
            memory_address_reg <= eff_addr;
            purpose <= PUR_INDIRECT;
            state <= ST_ACCESS;
          end else begin
            instruction_work_reg[ADDR_W-1:0] <= eff_addr;
            instruction_work_reg[INDEX_BIT] <= 1'b0;
            memory_address_reg <= eff_addr;
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (instruction_work_reg[POP_BIT]) begin
            memory_buffer_reg <= {^program_counter_reg,
              10'h000, program_counter_reg};
            memory_address_reg <= RETURN_SLOT;
            purpose <= PUR_POP;
            state <= ST_ACCESS;
          end else if (decode_word == WORD_COPY_EXT_TO_ACC_CLEAR) begin
            accumulator_reg <= extension_reg;
            extension_reg <= WORD_RESET;
            program_counter_reg <= pc_next;
            state <= ST_FETCH;
          end else if (decode_word == WORD_OVERFLOW_TEST_RESET) begin
            // Skip when the indicator was clear, then clear it
            program_counter_reg <= overflow ? pc_next : pc_skip;
            overflow <= 1'b0;
            state <= ST_FETCH;
          end else begin
            case (opcode_reg)
              OPC_HALT: begin
                program_counter_reg <= pc_next;
                halt_instr <= 1'b1;
                state <= ST_IDLE;
              end
              OPC_SKIP_IF_GREATER, OPC_ADD, OPC_LOAD_ACC: begin
                purpose <= PUR_OPERAND;
                state <= ST_ACCESS;
              end
              OPC_STORE_ACC: begin
                memory_buffer_reg <= {^accumulator_reg,
                  accumulator_reg};
                purpose <= PUR_STORE;
                state <= ST_ACCESS;
              end
              default: begin
                program_counter_reg <= pc_next;
                state <= ST_FETCH;
              end
            endcase
          end
        end
        ST_ACCESS: begin
          if (!mem_busy) begin
            if (power_fail) begin
              halt_power <= 1'b1;
              state <= ST_IDLE;
            end else if (addr_avail && mem_addr == memory_address_reg) begin
              // Pins settle one cycle ahead of the request
              mem_busy <= 1'b1;
              mem_read <= is_read;
              mem_write <= !is_read;
              mem_wdata <= memory_buffer_reg;
            end
          end else if (mem_done) begin
            mem_busy <= 1'b0;
            mem_read <= 1'b0;
            mem_write <= 1'b0;
          end
          if (access_done) begin
            if (is_read) begin
              memory_buffer_reg <= rd_word;
            end
            case (purpose)
              PUR_FETCH: begin
                instruction_work_reg <= rd_word[WORD_W-1:0];
                opcode_reg <= rd_word[OPC_HI:OPC_LO];
                state <= ST_MODIFY;
              end
              PUR_INDIRECT: begin
                // Re-decode as an address word; opcode is kept
                instruction_work_reg[INDEX_BIT] <= rd_word[INDEX_BIT];
                instruction_work_reg[INDIRECT_BIT] <= rd_word[INDIRECT_BIT];
                instruction_work_reg[ADDR_W-1:0] <= rd_word[ADDR_W-1:0];
                state <= ST_MODIFY;
              end
              PUR_OPERAND: begin
                case (opcode_reg)
                  OPC_SKIP_IF_GREATER: begin
                    program_counter_reg <= ($signed(accumulator_reg) >
                      $signed(rd_word[WORD_W-1:0])) ?
                      pc_skip : pc_next;
                  end
                  OPC_ADD: begin
                    accumulator_reg <= add_sum;
                    if (add_ovf) begin
                      overflow <= 1'b1;
                    end
                    program_counter_reg <= pc_next;
                  end
                  default: begin
                    accumulator_reg <= rd_word[WORD_W-1:0];
                    program_counter_reg <= pc_next;
                  end
                endcase
                state <= ST_FETCH;
              end
              PUR_STORE: begin
                program_counter_reg <= pc_next;
                state <= ST_FETCH;
              end
              PUR_POP: begin
                program_counter_reg <= {7'h00,
                  instruction_work_reg[POP_BIT:OPC_LO]};
                state <= ST_FETCH;
              end
              default: begin
                state <= ST_FETCH;
              end
            endcase
          end
          // Parity error outranks completion and a same-cycle clear
          if (read_parity_bad) begin
            parity_err <= 1'b1;
            if (parity_halt_en) begin
              halt_parity <= 1'b1;
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Memory address pins follow the address register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr <= ADDR_RESET;
    end else begin
      mem_addr <= memory_address_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_running <= 1'b0;
    end else begin
      cpu_running <= (state != ST_IDLE);
    end
  end

  // ==========================================================
  // APB slave: one wait state, read data registered
  logic [31:0] rd_mux;
  logic rd_hit;

  always_comb begin
    rd_mux = PRDATA_RESET;
    rd_hit = 1'b1;
    case (paddr)
      REG_CTRL: rd_mux[CTRL_PARITY_HALT] = parity_halt_en;
      REG_STATUS: begin
        rd_mux[STAT_RUNNING] = (state != ST_IDLE);
        rd_mux[STAT_HALT_POWER] = halt_power;
        rd_mux[STAT_HALT_PARITY] = halt_parity;
        rd_mux[STAT_HALT_INSTR] = halt_instr;
        rd_mux[STAT_PARITY_ERR] = parity_err;
        rd_mux[STAT_OVERFLOW] = overflow;
      end
      REG_PC: rd_mux[ADDR_W-1:0] = program_counter_reg;
      REG_ACC: rd_mux[WORD_W-1:0] = accumulator_reg;
      REG_EXT: rd_mux[WORD_W-1:0] = extension_reg;
      REG_INDEX: rd_mux[WORD_W-1:0] = index_reg;
      REG_IWR: rd_mux[WORD_W-1:0] = instruction_work_reg;
      REG_OPCODE: rd_mux[OPC_W-1:0] = opcode_reg;
      REG_MAR: rd_mux[ADDR_W-1:0] = memory_address_reg;
      REG_MBR: rd_mux[MEM_W-1:0] = memory_buffer_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= PRDATA_RESET;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !rd_hit;
      prdata <= pwrite ? PRDATA_RESET : rd_mux;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // word_cpu_core

// ==== rtl/word_cpu_pkg.sv ====
// Constants and types shared by the word processor core
package word_cpu_pkg;

  // ==========================================================
  // Word layout (bit 0 is the least significant bit of the word)
  localparam int WORD_W = 24;
  localparam int MEM_W = 25;
  localparam int ADDR_W = 14;
  localparam int OPC_W = 6;
  localparam int PADDR_W = 8;
  localparam int PAR_BIT = 24;
  localparam int INDEX_BIT = 22;
  localparam int POP_BIT = 21;
  localparam int OPC_HI = 20;
  localparam int OPC_LO = 15;
  localparam int INDIRECT_BIT = 14;

  // ==========================================================
  // Operation codes and full-word instructions
  localparam logic [5:0] OPC_HALT = 6'h00;
  localparam logic [5:0] OPC_STORE_ACC = 6'h1D;
  localparam logic [5:0] OPC_ADD = 6'h2D;
  localparam logic [5:0] OPC_SKIP_IF_GREATER = 6'h3B;
  localparam logic [5:0] OPC_LOAD_ACC = 6'h3E;
  localparam logic [22:0] WORD_COPY_EXT_TO_ACC_CLEAR = 23'h131000;
  localparam logic [22:0] WORD_OVERFLOW_TEST_RESET = 23'h102001;
  localparam logic [13:0] RETURN_SLOT = 14'h0000;

  // ==========================================================
  // APB register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;
  localparam logic [7:0] REG_ACC = 8'h0C;
  localparam logic [7:0] REG_EXT = 8'h10;
  localparam logic [7:0] REG_INDEX = 8'h14;
  localparam logic [7:0] REG_IWR = 8'h18;
  localparam logic [7:0] REG_OPCODE = 8'h1C;
  localparam logic [7:0] REG_MAR = 8'h20;
  localparam logic [7:0] REG_MBR = 8'h24;

  // Field positions in CTRL and STATUS
  localparam int CTRL_PARITY_HALT = 0;
  localparam int CTRL_START = 1;
  localparam int STAT_RUNNING = 0;
  localparam int STAT_HALT_POWER = 1;
  localparam int STAT_HALT_PARITY = 2;
  localparam int STAT_HALT_INSTR = 3;
  localparam int STAT_PARITY_ERR = 4;
  localparam int STAT_OVERFLOW = 5;

  // ==========================================================
  // Reset values
  localparam logic [23:0] WORD_RESET = 24'h000000;
  localparam logic [24:0] MEM_WORD_RESET = 25'h0000000;
  localparam logic [13:0] ADDR_RESET = 14'h0000;
  localparam logic [5:0] OPC_RESET = 6'h00;
  localparam logic [31:0] PRDATA_RESET = 32'h00000000;

  // ==========================================================
  // Sequencer states and purposes of a memory access
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_FETCH = 5'b00010,
    ST_MODIFY = 5'b00100,
    ST_EXEC = 5'b01000,
    ST_ACCESS = 5'b10000
  } cpu_state_t;

  typedef enum logic [4:0] {
    PUR_FETCH = 5'b00001,
    PUR_INDIRECT = 5'b00010,
    PUR_OPERAND = 5'b00100,
    PUR_STORE = 5'b01000,
    PUR_POP = 5'b10000
  } access_purpose_t;

endpackage

// ==== test/core_mem_model.sv ====
// Behavioural core memory bank answering the processor's access port
`timescale 1ns/1ns
module core_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic [word_cpu_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic [word_cpu_pkg::MEM_W-1:0] mem_wdata,
  output logic [word_cpu_pkg::MEM_W-1:0] mem_rdata,
  output logic mem_done
);
  import word_cpu_pkg::*;
  // Full 16K bank: only the core may keep to the installed size
  logic [MEM_W-1:0] words [0:16383];
  logic [1:0] wait_cnt;
  logic go;
  initial begin
    for (int i = 0; i < 16384; i++) begin
      words[i] = MEM_WORD_RESET;
    end
  end
  assign go = (mem_read || mem_write) && !mem_done &&
              wait_cnt == (slow ? 2'd3 : 2'd0);
  // Word kept whole, parity bit as sent
  always @(posedge pclk) begin
    if (go && mem_write) begin
      words[mem_addr] <= mem_wdata;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_done <= 1'b0;
      wait_cnt <= 2'd0;
      mem_rdata <= MEM_WORD_RESET;
    end else if (mem_done) begin
      // Lines stop showing the word once the pulse is over
      mem_done <= 1'b0;
      wait_cnt <= 2'd0;
      mem_rdata <= ~mem_rdata;
    end else if (go) begin
      mem_done <= 1'b1;
      if (mem_read) begin
        mem_rdata <= words[mem_addr];
      end
    end else if (mem_read || mem_write) begin
      wait_cnt <= wait_cnt + 2'd1;
    end
  end
endmodule // core_mem_model

// ==== test/testbench.sv ====
// Self-checking bench for the processor core and its memory port
`timescale 1ns/1ns
module testbench;
  import word_cpu_pkg::*;
  typedef struct {
    logic [31:0] ins, acc, ext, idx, eacc, eext, epc;
  } row_t;
  localparam logic [31:0] START = 32'h1 << CTRL_START;
  localparam int D1 = 'h123456;
  logic pclk = 1'b0;
  logic presetn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [PADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, mem_read, mem_write, mem_done, cpu_running, e;
  logic [ADDR_W-1:0] mem_addr;
  logic [MEM_W-1:0] mem_wdata, mem_rdata;
  logic power_fail = 1'b0;
  logic slow = 1'b0;
  int fail_count = 0;
  int total_checks = 0;
  row_t rows [$];
  always #20 pclk = ~pclk;
  word_cpu_core #(.MEM_WORDS(4096)) word_cpu_core_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_addr(mem_addr), .mem_read(mem_read),
    .mem_write(mem_write), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_done(mem_done), .power_fail(power_fail), .cpu_running(cpu_running));
  core_mem_model core_mem_model_inst (.pclk(pclk), .presetn(presetn),
    .slow(slow), .mem_addr(mem_addr), .mem_read(mem_read),
    .mem_write(mem_write), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_done(mem_done));
  // ==========================================================
  // Helpers
  function automatic int mk(int f, int op, int ad);
    return (f >> 1 << 22) | (op << 15) | ((f & 1) << 14) | ad;
  endfunction
  function automatic logic [MEM_W-1:0] enc(logic [23:0] d);
    return {^d, d};
  endfunction
  task automatic put(input int a, input int d);
    core_mem_model_inst.words[a] = enc(24'(d));
  endtask
  task automatic row(input int ins, a, x, i, ea, ee, ep);
    rows.push_back('{ins, a, x, i, ea, ee, ep});
  endtask
  task automatic chk(input string name, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  // Entered just after a rising edge; leaves one idle cycle behind
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic run(input logic [31:0] ctrl);
    int n;
    n = 0;
    apb(1'b1, REG_CTRL, ctrl);
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (q[STAT_RUNNING] !== 1'b0 && n < 100);
    if (n >= 100) fail_count++;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    presetn <= 1'b0;
    row(mk(0, OPC_LOAD_ACC, 'h200), 0, 0, 0, D1, 0, 'h102);
    row(mk(2, OPC_LOAD_ACC, 'h1F0), 0, 0, 'hFF0010, D1, 0, 'h102);
    row(mk(2, OPC_LOAD_ACC, 'h3FF0), 0, 0, 'h210, D1, 0, 'h102);
    row(mk(1, OPC_LOAD_ACC, 'h300), 0, 0, 0, D1, 0, 'h102);
    row(mk(0, OPC_LOAD_ACC, 'h200) | 'h800000, 0, 0, 0, D1, 0, 'h102);
    row(mk(0, OPC_LOAD_ACC, 'h1000), 7, 0, 0, 0, 0, 'h102);
    row(mk(0, OPC_SKIP_IF_GREATER, 'h201), 'h100, 0, 0, 'h100, 0, 'h103);
    row(mk(0, OPC_SKIP_IF_GREATER, 'h201), 'h10, 0, 0, 'h10, 0, 'h102);
    row(mk(0, OPC_SKIP_IF_GREATER, 'h202), 1, 0, 0, 1, 0, 'h103);
    row(WORD_COPY_EXT_TO_ACC_CLEAR, 5, 'hABCDE, 0, 'hABCDE, 0, 'h102);
    row(mk(0, OPC_STORE_ACC, 'h210), 'h654321, 0, 0, 'h654321, 0, 'h102);
    row(mk(0, OPC_STORE_ACC, 'h1000), 'h7777, 0, 0, 'h7777, 0, 'h102);
    row(WORD_OVERFLOW_TEST_RESET, 0, 0, 0, 0, 0, 'h103);
    row('h228000, 3, 0, 0, 3, 0, 'h046);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a <= 36; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk("reset value", 32'h0, q);
    end
    put('h200, D1);
    put('h201, 'h50);
    put('h202, 'hFFFFFF);
    put('h203, 1);
    put('h300, 'h200);
    put('h1000, 'h5A5A5A);
    foreach (rows[i]) begin
      slow <= i[0];
      put('h100, rows[i].ins);
      apb(1'b1, REG_PC, 32'h100);
      apb(1'b1, REG_ACC, rows[i].acc);
      apb(1'b1, REG_EXT, rows[i].ext);
      apb(1'b1, REG_INDEX, rows[i].idx);
      run(START);
      apb(1'b0, REG_ACC, 32'h0);
      chk("acc", rows[i].eacc, q);
      apb(1'b0, REG_EXT, 32'h0);
      chk("ext", rows[i].eext, q);
      apb(1'b0, REG_PC, 32'h0);
      chk("pc", rows[i].epc, q);
    end
    chk("stored word", 32'(enc(24'h654321)), 32'(core_mem_model_inst.words['h210]));
    chk("missing word", 32'(enc(24'h5A5A5A)), 32'(core_mem_model_inst.words['h1000]));
    chk("return slot", 32'(enc(24'h000100)), 32'(core_mem_model_inst.words[0]));
    // Overflow from an add must stop the test from skipping
    put('h100, mk(0, OPC_ADD, 'h203));
    put('h101, WORD_OVERFLOW_TEST_RESET);
    apb(1'b1, REG_PC, 32'h100);
    apb(1'b1, REG_ACC, 32'h7FFFFF);
    run(START);
    apb(1'b0, REG_PC, 32'h0);
    chk("pc", 32'h103, q);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", 32'h08, q);
    // Word stored with odd parity, with the halt switch off then on
    core_mem_model_inst.words['h205] = {1'b0, 24'h000001};
    put('h100, mk(0, OPC_LOAD_ACC, 'h205));
    for (int sw = 0; sw < 2; sw++) begin
      apb(1'b1, REG_PC, 32'h100);
      run(START | 32'(sw));
      apb(1'b0, REG_STATUS, 32'h0);
      chk("status", sw ? 32'h14 : 32'h18, q);
      apb(1'b1, REG_STATUS, 32'h10);
      apb(1'b0, REG_STATUS, 32'h0);
      chk("status", sw ? 32'h04 : 32'h08, q);
    end
    // Fetch from the last address reads zeros, halts, and wraps the counter
    apb(1'b1, REG_PC, 32'h3FFF);
    run(START);
    apb(1'b0, REG_PC, 32'h0);
    chk("pc", 32'h0, q);
    power_fail <= 1'b1;
    apb(1'b1, REG_PC, 32'h100);
    run(START);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", 32'h02, q);
    power_fail <= 1'b0;
    apb(1'b1, 8'hFC, 32'hFFFFFFFF);
    chk("pslverr", 32'h1, {31'h0, e});
    apb(1'b0, 8'hFC, 32'h0);
    chk("pslverr", 32'h1, {31'h0, e});
    chk("prdata", 32'h0, q);
    // Reset again in the middle of an access
    slow <= 1'b1;
    apb(1'b1, REG_CTRL, START);
    repeat (2) @(posedge pclk);
    chk("running", 32'h1, {31'h0, cpu_running});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("running", 32'h0, {31'h0, cpu_running});
    apb(1'b0, REG_PC, 32'h0);
    chk("pc", 32'h0, q);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", 32'h0, q);
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    report_and_stop();
  end
endmodule // testbench

bind word_cpu_core word_cpu_props #(.MEM_WORDS(MEM_WORDS)) props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr),
  .mem_read(mem_read), .mem_write(mem_write), .mem_wdata(mem_wdata),
  .mem_rdata(mem_rdata), .mem_done(mem_done), .power_fail(power_fail),
  .cpu_running(cpu_running));

// ==== test/word_cpu_props.sv ====
// Concurrent checks on the processor core ports
`timescale 1ns/1ns
module word_cpu_props #(
  parameter int MEM_WORDS = 4096
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [word_cpu_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [word_cpu_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic [word_cpu_pkg::MEM_W-1:0] mem_wdata,
  input wire logic [word_cpu_pkg::MEM_W-1:0] mem_rdata,
  input wire logic mem_done,
  input wire logic power_fail,
  input wire logic cpu_running
);
  import word_cpu_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Register bus
  a_apb_wait_state: assert property (
    psel && $rose(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // ==========================================================
  // Memory port
  a_addr_in_range: assert property (
    (mem_read || mem_write) |-> mem_addr < MEM_WORDS)
    else $error("access beyond installed memory");
  a_addr_settled: assert property (
    $rose(mem_read) || $rose(mem_write) |-> $stable(mem_addr))
    else $error("address not set before request");
  a_power_gate: assert property (
    $rose(mem_read) || $rose(mem_write) |-> !$past(power_fail))
    else $error("access started during power loss");
  a_even_parity: assert property (mem_write |-> !(^mem_wdata))
    else $error("write word has odd parity");
  a_read_held: assert property (
    mem_read && !mem_done |=> mem_read && $stable(mem_addr))
    else $error("read request not held");
  a_write_held: assert property (
    mem_write && !mem_done |=> mem_write && $stable({mem_addr, mem_wdata}))
    else $error("write request not held");
  a_req_drop: assert property (mem_done |=> !mem_read && !mem_write)
    else $error("request not dropped after done");
  a_one_access: assert property (!(mem_read && mem_write))
    else $error("read and write together");
  c_store: cover property (mem_write && mem_done);
  c_unmapped: cover property (pslverr);
  c_halt: cover property ($fell(cpu_running));
endmodule // word_cpu_props
